// ### rtl/data_eeprom_sfr_access.sv
// data eeprom controller behind three special function registers
// assumes the core drives sfr_addr with one-cycle write strobes on mclk
// What this block does
// - 512 bytes, nine-bit address, registers only
// - low address register holds bits 7..0
// - control holds address bit 8, mode, flag
// - data register writes and returns bytes
// - byte mode moves one byte per operation
// - byte write lasts about 4 ms
// - byte read ready three machine cycles later
// - row fill writes pattern to 64 bytes
// - row fill lasts about 4 ms
// - block fill writes pattern to all bytes
// - block fill lasts about 4 ms
// - every finished operation sets the flag
// - interrupt when flag, enable, global enable
// - flag stays set until software clears it
// - mode 00 byte, 10 row, 11 block
// - byte mode: data then address writes; address alone reads
// - reset forgets pending data write
// - last data written is programmed
`timescale 1ns/100ps
`default_nettype none
module data_eeprom_sfr_access #(
   parameter int PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic eeprom_irq_enable,
   input wire logic global_irq_enable,
   output logic irq_request,
   output logic busy
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] eeprom_low_address;
   logic [7:0] eeprom_data_value;
   logic operation_complete_flag;
   logic [1:0] operation_mode_field;
   logic address_high_bit;
   logic data_pending;
   logic [7:0] array_mem [0:eeprom_pkg::ARRAY_BYTES-1];
   eeprom_pkg::state_type state;
   eeprom_pkg::mode_type op_mode;
   logic [8:0] op_addr;
   logic [7:0] op_data;
   logic op_write;
   logic [31:0] timer;
   logic finish;
   logic wr_low, wr_ctl, wr_dat, start;
   logic start_write;
   logic [2:0] op_row;
   logic [7:0] control_view;
   logic read_done, write_done;

   // register write decode; nothing is taken while the enable is low
   always_comb begin
      wr_low = 1'b0;
      wr_ctl = 1'b0;
      wr_dat = 1'b0;
      if (clk_en && sfr_write) begin
         if (sfr_addr == eeprom_pkg::ADDR_LOW_ADDRESS) begin
            wr_low = 1'b1;
         end else if (sfr_addr == eeprom_pkg::ADDR_CONTROL) begin
            wr_ctl = 1'b1;
         end else if (sfr_addr == eeprom_pkg::ADDR_DATA_VALUE) begin
            wr_dat = 1'b1;
         end
      end
   end

   // mode 01 undefined: treated as no operation
   assign start = wr_low && state == eeprom_pkg::ST_IDLE
      && operation_mode_field != eeprom_pkg::MODE_RESERVED;
   assign finish = clk_en && state != eeprom_pkg::ST_IDLE && timer == 32'h0000_0001;
   assign busy = state != eeprom_pkg::ST_IDLE;
   assign irq_request = operation_complete_flag && eeprom_irq_enable && global_irq_enable;
   // a byte-mode start with no armed data is a read; fills always program
   assign start_write = operation_mode_field != eeprom_pkg::MODE_BYTE || data_pending;
   // row fill compares only the row number, so low address bits 5..0 never matter
   assign op_row = op_addr[8:6];
   assign read_done = finish && !op_write;
   assign write_done = finish && op_write;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         operation_mode_field <= eeprom_pkg::CONTROL_RESET[eeprom_pkg::MODE_HI_BIT:eeprom_pkg::MODE_LO_BIT];
         address_high_bit <= eeprom_pkg::CONTROL_RESET[eeprom_pkg::ADDR_HIGH_BIT];
      end else if (wr_ctl && !busy) begin
         // mode and bit 8 are frozen while busy so a running job keeps its meaning
         operation_mode_field <= sfr_wdata[eeprom_pkg::MODE_HI_BIT:eeprom_pkg::MODE_LO_BIT];
         address_high_bit <= sfr_wdata[eeprom_pkg::ADDR_HIGH_BIT];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         operation_complete_flag <= eeprom_pkg::CONTROL_RESET[eeprom_pkg::FLAG_BIT];
      end else if (finish) begin
         // set beats a same-cycle clear by software
         operation_complete_flag <= 1'b1;
      end else if (wr_ctl && !sfr_wdata[eeprom_pkg::FLAG_BIT]) begin
         operation_complete_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         eeprom_low_address <= 8'h00;
      end else if (wr_low && !busy) begin
         // the address register keeps the running job's location readable
         eeprom_low_address <= sfr_wdata;
      end
   end

   // only writes in byte mode arm a write; reset clears the memory of it
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_pending <= 1'b0;
      end else if (start) begin
         data_pending <= 1'b0;
      end else if (wr_dat && !busy && operation_mode_field == eeprom_pkg::MODE_BYTE) begin
         data_pending <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         eeprom_data_value <= eeprom_pkg::DATA_RESET;
      end else if (read_done) begin
         eeprom_data_value <= array_mem[op_addr];
      end else if (wr_dat && !busy) begin
         eeprom_data_value <= sfr_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // job parameters are captured at the start edge; later register writes cannot disturb a running job
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         op_mode <= eeprom_pkg::MODE_BYTE;
         op_addr <= 9'h000;
         op_data <= eeprom_pkg::DATA_RESET;
         op_write <= 1'b0;
      end else if (start) begin
         op_mode <= eeprom_pkg::mode_type'(operation_mode_field);
         op_addr <= {address_high_bit, sfr_wdata};
         op_data <= eeprom_data_value;
         op_write <= start_write;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= eeprom_pkg::ST_IDLE;
         timer <= 32'h0000_0000;
      end else if (clk_en) begin
         case (state)
            eeprom_pkg::ST_IDLE: begin
               if (start && !start_write) begin
                  state <= eeprom_pkg::ST_READ;
                  timer <= 32'(eeprom_pkg::READ_CYCLES);
               end else if (start) begin
                  // one fixed program time covers byte write, row fill and block fill
                  state <= eeprom_pkg::ST_PROGRAM;
                  timer <= 32'(PROGRAM_CYCLES);
               end
            end
            eeprom_pkg::ST_READ, eeprom_pkg::ST_PROGRAM: begin
               timer <= timer - 32'h0000_0001;
               if (timer == 32'h0000_0001) begin
                  state <= eeprom_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= eeprom_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // array contents are not reset: nonvolatile storage
   always_ff @(posedge mclk) begin
      if (write_done) begin
         for (int i = 0; i < eeprom_pkg::ARRAY_BYTES; i++) begin
            if (op_mode == eeprom_pkg::MODE_BYTE && 9'(i) == op_addr) begin
               array_mem[i] <= op_data;
            end else if (op_mode == eeprom_pkg::MODE_ROW && 3'(i / eeprom_pkg::ROW_BYTES) == op_row) begin
               array_mem[i] <= op_data;
            end else if (op_mode == eeprom_pkg::MODE_BLOCK) begin
               array_mem[i] <= op_data;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // unused control bits read back as zero
   always_comb begin
      control_view = 8'h00;
      control_view[eeprom_pkg::FLAG_BIT] = operation_complete_flag;
      control_view[eeprom_pkg::MODE_HI_BIT:eeprom_pkg::MODE_LO_BIT] = operation_mode_field;
      control_view[eeprom_pkg::ADDR_HIGH_BIT] = address_high_bit;
   end

   // read data is registered: the core sees it one enabled cycle after the address
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else if (clk_en) begin
         if (sfr_addr == eeprom_pkg::ADDR_CONTROL) begin
            sfr_rdata <= control_view;
         end else if (sfr_addr == eeprom_pkg::ADDR_LOW_ADDRESS) begin
            sfr_rdata <= eeprom_low_address;
         end else if (sfr_addr == eeprom_pkg::ADDR_DATA_VALUE) begin
            sfr_rdata <= eeprom_data_value;
         end else begin
            sfr_rdata <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/eeprom_pkg.sv
// constants for the data eeprom register controller
// assumes an sfr bus with 8-bit addresses and one-cycle write/read strobes
package eeprom_pkg;
   localparam logic [7:0] ADDR_LOW_ADDRESS = 8'hF2;
   localparam logic [7:0] ADDR_CONTROL = 8'hF1;
   localparam logic [7:0] ADDR_DATA_VALUE = 8'hF3;
   localparam int FLAG_BIT = 7;
   localparam int MODE_HI_BIT = 5;
   localparam int MODE_LO_BIT = 4;
   localparam int ADDR_HIGH_BIT = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int ARRAY_BYTES = 512;
   localparam int ROW_BYTES = 64;
   localparam int CLOCK_HZ = 25000000;
   localparam int PROGRAM_TIME_US = 4000;
   localparam int PROGRAM_CYCLES = (CLOCK_HZ / 1000000) * PROGRAM_TIME_US;
   localparam int MACHINE_CYCLE_CLOCKS = 2;
   localparam int READ_MACHINE_CYCLES = 3;
   localparam int READ_CYCLES = MACHINE_CYCLE_CLOCKS * READ_MACHINE_CYCLES;
   typedef enum logic [1:0] {
      MODE_BYTE = 2'b00,
      MODE_RESERVED = 2'b01,
      MODE_ROW = 2'b10,
      MODE_BLOCK = 2'b11
   } mode_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_PROGRAM = 2'b10
   } state_type;
endpackage

// ### test/core_model.sv
// core model: drives the register bus
// assumes one-cycle write strobes at falling edges
`timescale 1ns/100ps
`default_nettype none
module core_model (
   input wire logic mclk,
   output logic [7:0] sfr_addr,
   output logic sfr_write,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata
);
   initial begin
      sfr_addr = 8'h00;
      sfr_write = 1'b0;
      sfr_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_write = 1'b1;
      @(negedge mclk);
      sfr_write = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      sfr_addr = a;
      @(negedge mclk);
      d = sfr_rdata;
   endtask
endmodule
`default_nettype wire

// ### test/data_eeprom_sfr_access_properties.sv
// checker on the top ports
// assumes it is bound to the eeprom controller
`timescale 1ns/100ps
`default_nettype none
module data_eeprom_sfr_access_properties #(
   parameter int PROGRAM_CYCLES = 20
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic eeprom_irq_enable,
   input wire logic global_irq_enable,
   input wire logic irq_request,
   input wire logic busy
);
   localparam int LIM = 3 * PROGRAM_CYCLES;
   logic [1:0] mode;
   logic ctl_write;
   logic low_write;
   assign ctl_write = clk_en && sfr_write && sfr_addr == eeprom_pkg::ADDR_CONTROL;
   assign low_write = clk_en && sfr_write && sfr_addr == eeprom_pkg::ADDR_LOW_ADDRESS;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // shadow of the mode field; writes while busy are dropped
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mode <= 2'b00;
      end else if (ctl_write && !busy) begin
         mode <= sfr_wdata[eeprom_pkg::MODE_HI_BIT:eeprom_pkg::MODE_LO_BIT];
      end
   end
   sequence start_s;
      low_write && !busy;
   endsequence
   sequence kept_s;
      irq_request && !ctl_write ##1 eeprom_irq_enable && global_irq_enable;
   endsequence
   a_start_busy: assert property (start_s ##0 mode != 2'b01 |=> busy)
      else $error("no start");
   a_quiet_idle: assert property (!busy && !low_write |=> !busy)
      else $error("stray start");
   a_read_span: assert property ($rose(busy) |-> busy[*6])
      else $error("op too short");
   a_op_bounded: assert property ($rose(busy) |-> ##[1:LIM] !busy)
      else $error("op too long");
   a_done_flags: assert property ($fell(busy) |-> irq_request == (eeprom_irq_enable && global_irq_enable))
      else $error("no flag at end");
   a_irq_gated: assert property (irq_request |-> eeprom_irq_enable && global_irq_enable)
      else $error("irq not gated");
   a_irq_holds: assert property (kept_s |-> irq_request)
      else $error("flag lost");
   a_rdata_frozen: assert property (!clk_en |=> $stable(sfr_rdata))
      else $error("rdata moved");
endmodule
`default_nettype wire

// ### test/test_data_eeprom_sfr_access.sv
// self-checking bench with an integer model of the array
// assumes the core model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_data_eeprom_sfr_access;
   localparam int P = 20;
   logic mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, sfr_write, irq_request, busy;
   logic eeprom_irq_enable = 1'b0, global_irq_enable = 1'b0;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
   int mismatches = 0, num_checks = 0, mem[512], a, p, q[$];
   initial forever #20 mclk = ~mclk;
   core_model core_model_i (.mclk(mclk), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata));
   data_eeprom_sfr_access #(.PROGRAM_CYCLES(P)) data_eeprom_sfr_access_i (.mclk(mclk), .rst_b(rst_b),
      .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .eeprom_irq_enable(eeprom_irq_enable), .global_irq_enable(global_irq_enable), .irq_request(irq_request),
      .busy(busy));
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         $display("unexpected %s exp %h seen %h", n, e, s);
         mismatches++;
      end
   endtask
   task automatic end_sim();
      $display("mismatches %0d checks %0d", mismatches, num_checks);
      if (mismatches == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // random enable stalls stretch the wait, so it is bounded, not fixed
   task automatic done();
      int i;
      i = 0;
      @(negedge mclk);
      while (busy !== 1'b0 && i < 200) begin
         clk_en = ($urandom % 4) != 0;
         @(negedge mclk);
         i++;
      end
      clk_en = 1'b1;
      if (i == 200) begin
         mismatches++;
         end_sim();
      end else begin
         chk("irq", irq_request, eeprom_irq_enable & global_irq_enable);
         core_model_i.rd(8'hF1, v);
         chk("flag", v[7], 1'b1);
         core_model_i.wr(8'hF1, v & 8'h7F);
         chk("cleared", irq_request, 1'b0);
      end
   endtask
   task automatic op(logic [7:0] c, logic [7:0] d, logic [7:0] ad);
      {eeprom_irq_enable, global_irq_enable} = 2'($urandom);
      core_model_i.wr(8'hF1, c);
      core_model_i.wr(8'hF3, d);
      core_model_i.wr(8'hF2, ad);
      core_model_i.wr(8'hF2, ~ad);
      core_model_i.wr(8'hF3, ~d);
      done();
   endtask
   initial begin
      void'($urandom(57));
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      core_model_i.rd(8'hF1, v);
      chk("control", v, 8'h00);
      chk("irq", irq_request, 1'b0);
      p = $urandom % 256;
      op(8'h31, 8'(p), 8'($urandom));
      foreach (mem[i]) mem[i] = p;
      a = $urandom % 512;
      p = $urandom % 256;
      op(8'(32'h20 | (a >> 8)), 8'(p), 8'(a));
      for (int i = 0; i < 64; i++) mem[(a & 448) + i] = p;
      q.push_back((a & 448) + 63);
      repeat (6) begin
         a = $urandom % 512;
         p = $urandom % 256;
         core_model_i.wr(8'hF1, 8'(a >> 8));
         core_model_i.wr(8'hF3, ~8'(p));
         op(8'(a >> 8), 8'(p), 8'(a));
         mem[a] = p;
         q.push_back(a);
      end
      q.push_back($urandom % 512);
      foreach (q[k]) begin
         core_model_i.wr(8'hF1, 8'(q[k] >> 8));
         core_model_i.wr(8'hF2, 8'(q[k]));
         done();
         core_model_i.rd(8'hF3, v);
         chk("data", v, 8'(mem[q[k]]));
      end
      core_model_i.wr(8'hF3, 8'h5A);
      rst_b = 1'b0;
      @(negedge mclk);
      rst_b = 1'b1;
      core_model_i.wr(8'hF2, 8'h00);
      repeat (10) @(negedge mclk);
      chk("busy", busy, 1'b0);
      core_model_i.rd(8'hF3, v);
      chk("data", v, 8'(mem[0]));
      core_model_i.wr(8'hF1, 8'h10);
      core_model_i.wr(8'hF2, 8'h00);
      chk("busy", busy, 1'b0);
      end_sim();
   end
endmodule
bind data_eeprom_sfr_access data_eeprom_sfr_access_properties #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) props_i (
   .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata),
   .sfr_rdata(sfr_rdata), .eeprom_irq_enable(eeprom_irq_enable), .global_irq_enable(global_irq_enable),
   .irq_request(irq_request), .busy(busy));
`default_nettype wire
